// ---- rtl/gpio_port.sv ----
// Eight-pin general-purpose port with direction, data, pull-up and
// function select registers behind an Avalon-MM slave.
// Assumes an on-chip serial unit and wake-up logic on the same clock;
// pins are asynchronous and are synchronised here.
//
// Behaviour
// - Direction bit one makes a general pin an output, zero an input.
// - Direction register is write-only, one bit per pin, resets to zero.
// - Output data register holds each output level, readable, writable, resets zero.
// - Data read of an output-direction bit returns the stored data bit.
// - Data read of an input-direction bit returns the sampled pin level.
// - Pull-up register has readable writable bits 5 to 0, resetting to zero.
// - A pull-up bit acts only while its direction bit is zero.
// - Pull-up bits 7 and 6 read zero and ignore writes.
// - A set alternate select takes the pin over regardless of direction.
// - With its select clear, a pin is general I/O under its direction bit.
// - Wake-up select bits choose general I/O at zero, wake-up at one.
// - Function bits 7 and 6 make pins 7 and 6 low-side open-drain.
`timescale 1ns/1ps
`default_nettype none

module gpio_port
	import port_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [BUS_ADDR_WIDTH-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [BUS_DATA_WIDTH-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [BUS_DATA_WIDTH-1:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic [PORT_WIDTH-1:0] port_pin_i,
	output logic [PORT_WIDTH-1:0] port_pin_o,
	output logic [PORT_WIDTH-1:0] port_pin_oe_n_o,
	output logic [PULLUP_WIDTH-1:0] pullup_enable_o,
	input wire logic transmit_select_i,
	input wire logic receiver_enable_bit_i,
	input wire logic serial_transmit_i,
	output logic serial_receive_o,
	output logic [WAKEUP_WIDTH-1:0] wakeup_input_o,
	output logic converter_trigger_input_o
);

	function automatic logic hits(input logic [BUS_ADDR_WIDTH-1:0] addr, input logic [3:0] offset);
		hits = (addr == offset);
	endfunction : hits

	bus_state_t bus_state_reg;
	bus_state_t bus_state_next;
	logic waitrequest_reg;
	logic [BUS_DATA_WIDTH-1:0] readdata_reg;
	logic [BUS_DATA_WIDTH-1:0] readdata_next;

	logic [PORT_WIDTH-1:0] direction_register;
	logic [PORT_WIDTH-1:0] output_data_register;
	logic [PULLUP_WIDTH-1:0] pullup_register;
	logic [PORT_WIDTH-1:0] function_select_register;

	logic [PULLUP_WIDTH-1:0] pullup_reg;
	logic [WAKEUP_WIDTH-1:0] wakeup_reg;
	logic trigger_reg;
	logic receive_reg;

	logic [PORT_WIDTH-1:0] pin_level_w;
	logic request_w;
	logic commit_w;
	logic write_commit_w;
	logic low_lane_w;
	logic [7:0] write_byte_w;
	logic sel_direction_w;
	logic sel_output_data_w;
	logic sel_pullup_w;
	logic sel_function_w;
	logic [PORT_WIDTH-1:0] data_view_w;
	logic [7:0] read_byte_w;
	logic [WAKEUP_WIDTH-1:0] wakeup_select_w;
	logic [PORT_WIDTH-1:0] alternate_w;
	logic [PORT_WIDTH-1:0] drive_w;
	logic [PORT_WIDTH-1:0] level_w;
	logic [PORT_WIDTH-1:0] open_drain_w;

	pin_sync #(
		.WIDTH(PORT_WIDTH)
	) u_pin_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.async_i(port_pin_i),
		.sync_o(pin_level_w)
	);

	// Bus handshake: a request is held by the master, answered one cycle later.
	assign request_w = avs_read_i | avs_write_i;
	assign commit_w = request_w & (bus_state_reg == BUS_ANSWER);
	assign write_commit_w = commit_w & avs_write_i & low_lane_w;
	assign low_lane_w = avs_byteenable_i[0];
	assign write_byte_w = avs_writedata_i[7:0];

	assign sel_direction_w = hits(avs_address_i, DIRECTION_OFFSET);
	assign sel_output_data_w = hits(avs_address_i, OUTPUT_DATA_OFFSET);
	assign sel_pullup_w = hits(avs_address_i, PULLUP_OFFSET);
	assign sel_function_w = hits(avs_address_i, FUNCTION_SELECT_OFFSET);

	always_comb begin
		bus_state_next = bus_state_reg;
		case (bus_state_reg)
			BUS_IDLE: begin
				if (request_w) begin
					bus_state_next = BUS_ANSWER;
				end
			end
			BUS_ANSWER: begin
				bus_state_next = BUS_IDLE;
			end
			default: begin
				bus_state_next = BUS_IDLE;
			end
		endcase
	end

	// Reads see the stored bit for outputs and the pin for inputs.
	assign data_view_w = (direction_register & output_data_register) | (~direction_register & pin_level_w);

	// The direction register reads as zero since it cannot be read back.
	assign read_byte_w = sel_output_data_w ? data_view_w :
		sel_pullup_w ? {2'b00, pullup_register} :
		sel_function_w ? function_select_register :
		8'h00;

	assign readdata_next = {24'h000000, read_byte_w};

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			bus_state_reg <= BUS_IDLE;
			waitrequest_reg <= 1'b1;
			readdata_reg <= '0;
		end else begin
			bus_state_reg <= bus_state_next;
			waitrequest_reg <= ~(request_w & (bus_state_reg == BUS_IDLE));
			if (avs_read_i && bus_state_reg == BUS_IDLE) begin
				readdata_reg <= readdata_next;
			end
		end
	end

	assign avs_waitrequest_o = waitrequest_reg;
	assign avs_readdata_o = readdata_reg;

	// Register writes take effect at the edge where waitrequest is low.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			direction_register <= DIRECTION_RESET;
			output_data_register <= OUTPUT_DATA_RESET;
			pullup_register <= PULLUP_RESET;
			function_select_register <= FUNCTION_SELECT_RESET;
		end else if (write_commit_w) begin
			if (sel_direction_w) begin
				direction_register <= write_byte_w;
			end
			if (sel_output_data_w) begin
				output_data_register <= write_byte_w;
			end
			if (sel_pullup_w) begin
				pullup_register <= write_byte_w[PULLUP_WIDTH-1:0];
			end
			if (sel_function_w) begin
				function_select_register <= write_byte_w;
			end
		end
	end

	// Pin function resolution.
	assign wakeup_select_w = function_select_register[WAKEUP_SELECT_LSB +: WAKEUP_WIDTH];
	assign alternate_w = {transmit_select_i, receiver_enable_bit_i, wakeup_select_w};

	// Alternate pins 6 to 0 are inputs; pin 7 under transmit select is an output.
	assign drive_w[TXD_PIN] = transmit_select_i | direction_register[TXD_PIN];
	assign drive_w[TXD_PIN-1:0] = ~alternate_w[TXD_PIN-1:0] & direction_register[TXD_PIN-1:0];

	assign level_w[TXD_PIN] = transmit_select_i ? serial_transmit_i : output_data_register[TXD_PIN];
	assign level_w[TXD_PIN-1:0] = output_data_register[TXD_PIN-1:0];

	assign open_drain_w = {function_select_register[PIN7_OPEN_DRAIN_BIT],
		function_select_register[PIN6_OPEN_DRAIN_BIT], 6'b000000};

	genvar gi;
	generate
		for (gi = 0; gi < PORT_WIDTH; gi++) begin : g_pin
			pin_driver u_pin_driver (
				.clk_i(clk_i),
				.sys_rst_i(sys_rst_i),
				.drive_i(drive_w[gi]),
				.level_i(level_w[gi]),
				.open_drain_i(open_drain_w[gi]),
				.pin_o(port_pin_o[gi]),
				.pin_oe_n_o(port_pin_oe_n_o[gi])
			);
		end
	endgenerate

	// Pull-ups, wake-up, trigger and receive routing, all registered.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pullup_reg <= '0;
			wakeup_reg <= '0;
			trigger_reg <= 1'b0;
			receive_reg <= 1'b1;
		end else begin
			pullup_reg <= pullup_register & ~direction_register[PULLUP_WIDTH-1:0];
			wakeup_reg <= wakeup_select_w & pin_level_w[WAKEUP_WIDTH-1:0];
			trigger_reg <= wakeup_select_w[TRIGGER_PIN] & pin_level_w[TRIGGER_PIN];
			receive_reg <= ~receiver_enable_bit_i | pin_level_w[RXD_PIN];
		end
	end

	assign pullup_enable_o = pullup_reg;
	assign wakeup_input_o = wakeup_reg;
	assign converter_trigger_input_o = trigger_reg;
	assign serial_receive_o = receive_reg;

endmodule : gpio_port

`default_nettype wire

// ---- rtl/pin_driver.sv ----
// Registered output stage for one port pin.
// Assumes the enable and level inputs are already resolved on clk_i.
`timescale 1ns/1ps
`default_nettype none

module pin_driver (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic drive_i,
	input wire logic level_i,
	input wire logic open_drain_i,
	output logic pin_o,
	output logic pin_oe_n_o
);

	logic active_w;
	logic pin_reg;
	logic oe_n_reg;

	// An open-drain pin only ever pulls low; a high level releases it.
	assign active_w = drive_i & ~(open_drain_i & level_i);

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			pin_reg <= 1'b0;
			oe_n_reg <= 1'b1;
		end else begin
			pin_reg <= level_i & ~open_drain_i;
			oe_n_reg <= ~active_w;
		end
	end

	assign pin_o = pin_reg;
	assign pin_oe_n_o = oe_n_reg;

endmodule : pin_driver

`default_nettype wire

// ---- rtl/pin_sync.sv ----
// Two-flop synchroniser for a group of pins.
// Assumes the inputs are asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// The first stage is read by the second stage only.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			meta_reg <= '0;
			sync_reg <= '0;
		end else begin
			meta_reg <= async_i;
			sync_reg <= meta_reg;
		end
	end

	assign sync_o = sync_reg;

endmodule : pin_sync

`default_nettype wire

// ---- rtl/port_pkg.sv ----
// Constants shared by the eight-pin port with pin multiplexing.
// Assumes a 32-bit Avalon-MM register bus with byte addresses.
package port_pkg;

	localparam int PORT_WIDTH = 8;
	localparam int PULLUP_WIDTH = 6;
	localparam int WAKEUP_WIDTH = 6;
	localparam int BUS_ADDR_WIDTH = 4;
	localparam int BUS_DATA_WIDTH = 32;

	// Byte offsets of the registers.
	localparam logic [3:0] DIRECTION_OFFSET = 4'h0;
	localparam logic [3:0] OUTPUT_DATA_OFFSET = 4'h4;
	localparam logic [3:0] PULLUP_OFFSET = 4'h8;
	localparam logic [3:0] FUNCTION_SELECT_OFFSET = 4'hc;

	// Values after reset.
	localparam logic [7:0] DIRECTION_RESET = 8'h00;
	localparam logic [7:0] OUTPUT_DATA_RESET = 8'h00;
	localparam logic [5:0] PULLUP_RESET = 6'h00;
	localparam logic [7:0] FUNCTION_SELECT_RESET = 8'h00;

	// Field positions inside the function select register.
	localparam int PIN7_OPEN_DRAIN_BIT = 7;
	localparam int PIN6_OPEN_DRAIN_BIT = 6;
	localparam int WAKEUP_SELECT_LSB = 0;

	// Pins with a serial or converter trigger alternate function.
	localparam int TXD_PIN = 7;
	localparam int RXD_PIN = 6;
	localparam int TRIGGER_PIN = 5;

	// Cycles from a taken request to the answer edge.
	localparam int BUS_ANSWER_CYCLES = 1;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ANSWER = 2'b10
	} bus_state_t;

endpackage : port_pkg

// ---- test/gpio_port_chk.sv ----
// Concurrent checks on the port's bus handshake and pin outputs.
// Assumes it is bound into gpio_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_chk
	import port_pkg::*;
(
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic [BUS_ADDR_WIDTH-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [BUS_DATA_WIDTH-1:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	input wire logic avs_waitrequest_o,
	input wire logic [PORT_WIDTH-1:0] port_pin_i,
	input wire logic [PORT_WIDTH-1:0] port_pin_o,
	input wire logic [PORT_WIDTH-1:0] port_pin_oe_n_o,
	input wire logic [PULLUP_WIDTH-1:0] pullup_enable_o,
	input wire logic transmit_select_i,
	input wire logic receiver_enable_bit_i,
	input wire logic serial_transmit_i,
	input wire logic serial_receive_o,
	input wire logic [WAKEUP_WIDTH-1:0] wakeup_input_o,
	input wire logic converter_trigger_input_o
);
	// Shadow registers follow each write at the edge where it takes effect.
	logic [7:0] dir_reg, dat_reg, pu_reg, fs_reg;
	wire logic wr_ok = avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0];
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			{dir_reg, dat_reg, pu_reg, fs_reg} <= '0;
		end else if (wr_ok) begin
			case (avs_address_i)
				DIRECTION_OFFSET: dir_reg <= avs_writedata_i[7:0];
				OUTPUT_DATA_OFFSET: dat_reg <= avs_writedata_i[7:0];
				PULLUP_OFFSET: pu_reg <= avs_writedata_i[7:0];
				FUNCTION_SELECT_OFFSET: fs_reg <= avs_writedata_i[7:0];
				default: ;
			endcase
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence s_take;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence
	sequence s_answer;
		!avs_waitrequest_o ##1 avs_waitrequest_o;
	endsequence
	a_bus_answer: assert property (s_take |=> s_answer) else $error("bus answer not one cycle");
	a_gpio_drive: assert property (port_pin_oe_n_o[5:0] == $past(~(dir_reg[5:0] & ~fs_reg[5:0])))
		else $error("general pin enable wrong");
	a_tx_route: assert property ($past(transmit_select_i && !fs_reg[7]) |->
		!port_pin_oe_n_o[7] && port_pin_o[7] == $past(serial_transmit_i)) else $error("transmit pin wrong");
	a_open_drain: assert property ($past(fs_reg[6] && !receiver_enable_bit_i) |->
		!port_pin_o[6] && port_pin_oe_n_o[6] == $past(!dir_reg[6] || dat_reg[6])) else $error("open drain wrong");
	a_pullup_follow: assert property (pullup_enable_o == $past(pu_reg[5:0] & ~dir_reg[5:0]))
		else $error("pull-up wrong");
	a_wake_route: assert property ($past(port_pin_i, 2) == $past(port_pin_i, 4) && $past(fs_reg, 2) == fs_reg |->
		wakeup_input_o == ($past(port_pin_i[5:0], 3) & fs_reg[5:0])) else $error("wake-up input wrong");
	a_trigger_pin: assert property (converter_trigger_input_o == ($past(port_pin_i[5], 3) & $past(fs_reg[5])))
		else $error("trigger does not follow pin 5");
	a_rx_idle: assert property (!$past(receiver_enable_bit_i) |-> serial_receive_o)
		else $error("receive not idle");
endmodule : gpio_port_chk
bind gpio_port gpio_port_chk gpio_port_chk_i (.*);
`default_nettype wire

// ---- test/gpio_port_tb.sv ----
// Self-checking bench: random register settings, pin levels and serial inputs.
// Assumes pin_world drives every pin that the port leaves released.
`timescale 1ns/1ps
`default_nettype none
module gpio_port_tb
	import port_pkg::*;
;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic rd = 1'b0, wr = 1'b0, tx_sel = 1'b0, rx_en = 1'b0, stx = 1'b0, wt, srx, trig;
	logic [2:0] sv;
	logic [3:0] addr = 4'h0, be = 4'hf;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [7:0] ext_lvl = 8'h00, ext_en = 8'hff, pin_i, pin_o, oe_n, dir, dat, pup, fs, e, lvl, pins;
	logic [5:0] pu, wake;
	int fail_count = 0, samples_checked = 0, seed = 75003, cycles = 0;
	gpio_port gpio_port_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .avs_address_i(addr), .avs_read_i(rd),
		.avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be), .avs_readdata_o(rdata),
		.avs_waitrequest_o(wt), .port_pin_i(pin_i), .port_pin_o(pin_o), .port_pin_oe_n_o(oe_n),
		.pullup_enable_o(pu), .transmit_select_i(tx_sel), .receiver_enable_bit_i(rx_en), .serial_transmit_i(stx),
		.serial_receive_o(srx), .wakeup_input_o(wake), .converter_trigger_input_o(trig));
	pin_world pin_world_i (.clk_i(clk_i), .pin_o_i(pin_o), .oe_n_i(oe_n), .pullup_i({2'b00, pu}),
		.ext_lvl_i(ext_lvl), .ext_en_i(ext_en), .pin_lvl_o(pin_i));
	initial begin
		forever #2.5 clk_i = ~clk_i;
	end
	task automatic close_out();
		$display("checked %0d, mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : close_out
	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 6000) begin
			fail_count++;
			close_out();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] x);
		samples_checked++;
		if (seen !== x) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, x);
		end
	endtask : check
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_i);
		rd <= !w;
		wr <= w;
		addr <= a;
		wdata <= d;
		@(posedge clk_i);
		while (wt !== 1'b0) @(posedge clk_i);
		q = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus
	task automatic rchk(input logic [3:0] a, input logic [31:0] x);
		bus(1'b0, a, 32'h0);
		check(q, x);
	endtask : rchk
	// Expected active-low enables; pin 6 is released while the receiver owns it.
	function automatic logic [7:0] drive_n(input logic [7:0] d, v, f, input logic t, r, s);
		logic [7:0] n;
		n = ~(d & ~f);
		n[6] = r | !d[6] | (f[6] & v[6]);
		n[7] = !(t | d[7]) | (f[7] & (t ? s : v[7]));
		return n;
	endfunction : drive_n
	task automatic reset_run();
		sys_rst_i <= 1'b1;
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		rchk(DIRECTION_OFFSET, 32'h0);
		rchk(OUTPUT_DATA_OFFSET, {24'h0, ext_lvl});
		rchk(PULLUP_OFFSET, 32'h0);
		rchk(FUNCTION_SELECT_OFFSET, 32'h0);
		check(32'(oe_n), 32'hff);
		$display("test reset done");
	endtask : reset_run
	initial begin
		reset_run();
		for (int n = 0; n < 40; n++) begin
			dir = n < 2 ? {8{n[0]}} : 8'($random(seed));
			dat = 8'($random(seed));
			pup = 8'($random(seed));
			fs = n < 2 ? ~dir : 8'($random(seed));
			sv = 3'($random(seed));
			pins = 8'($random(seed));
			tx_sel <= sv[0];
			rx_en <= sv[1];
			stx <= sv[2];
			ext_lvl <= pins;
			lvl = {sv[0] ? sv[2] : dat[7], dat[6:0]};
			e = drive_n(dir, dat, fs, sv[0], sv[1], sv[2]);
			pins = (e & pins) | (~e & lvl);
			ext_en <= e;
			bus(1'b1, DIRECTION_OFFSET, {24'h0, dir});
			bus(1'b1, OUTPUT_DATA_OFFSET, {24'h0, dat});
			bus(1'b1, PULLUP_OFFSET, {24'h0, pup});
			bus(1'b1, FUNCTION_SELECT_OFFSET, {24'h0, fs});
			repeat (5) @(posedge clk_i);
			rchk(OUTPUT_DATA_OFFSET, {24'h0, (dir & dat) | (~dir & pins)});
			rchk(PULLUP_OFFSET, {26'h0, pup[5:0]});
			rchk(FUNCTION_SELECT_OFFSET, {24'h0, fs});
			rchk(DIRECTION_OFFSET, 32'h0);
			check(32'(oe_n), 32'(e));
			check(32'(pin_o & ~e), 32'(lvl & ~e));
			check(32'(pu), 32'(pup[5:0] & ~dir[5:0]));
			check(32'({srx, trig, wake}), 32'({sv[1] ? pins[6] : 1'b1, fs[5] & pins[5], fs[5:0] & pins[5:0]}));
		end
		$display("test random done");
		be <= 4'he;
		bus(1'b1, OUTPUT_DATA_OFFSET, {24'h0, ~dat});
		be <= 4'hf;
		bus(1'b1, 4'h2, 32'hff);
		rchk(OUTPUT_DATA_OFFSET, {24'h0, (dir & dat) | (~dir & pins)});
		rchk(4'h2, 32'h0);
		$display("test refusal done");
		ext_en <= 8'hff;
		tx_sel <= 1'b0;
		rx_en <= 1'b0;
		reset_run();
		close_out();
	end
endmodule : gpio_port_tb
`default_nettype wire

// ---- test/pin_world.sv ----
// Board model around the port: external drivers, pull-ups and floating pins.
// Assumes the bench owns ext_lvl_i and ext_en_i and runs clk_i.
`timescale 1ns/1ps
`default_nettype none
module pin_world (
	input wire logic clk_i,
	input wire logic [7:0] pin_o_i,
	input wire logic [7:0] oe_n_i,
	input wire logic [7:0] pullup_i,
	input wire logic [7:0] ext_lvl_i,
	input wire logic [7:0] ext_en_i,
	output logic [7:0] pin_lvl_o
);
	logic wobble_reg = 1'b0;
	always @(posedge clk_i) begin
		wobble_reg <= !wobble_reg;
	end
	// A floating pin without pull-up changes every cycle, so a stale level never reads as valid.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!oe_n_i[i]) pin_lvl_o[i] = pin_o_i[i];
			else if (ext_en_i[i]) pin_lvl_o[i] = ext_lvl_i[i];
			else if (pullup_i[i]) pin_lvl_o[i] = 1'b1;
			else pin_lvl_o[i] = wobble_reg ^ i[0];
		end
	end
endmodule : pin_world
`default_nettype wire
